// file: src/ptd_target.sv
// Function
// RULE1: One or two address clocks, then data; the target never claims a dual address cycle
// RULE2: Byte zero on lowest eight lines
// RULE3: Driven lines held stable every phase
// RULE4: Compare all thirty-two address lines
// RULE5: Low two bits give configuration type
// RULE6: Bits 7:2 register, 10:8 function
// RULE7: Claim configuration on command, select, type0
// RULE8: Master aborts unclaimed type 0 access
// RULE9: I/O base match, low byte selects
// RULE10: Enabled I/O match claims at medium speed
// RULE11: Write waits, steers byte, three clocks
// RULE12: Read waits turnaround plus register delay
// RULE13: Memory low bits give burst order
// RULE14: Only linear increment order supported
// RULE15: Memory base match, byte enables pick
// RULE16: Nobody drives during turnaround clock
// RULE17: Names marked low are active low
// RULE18: Several enables on byte register abort
// RULE19: Bursts disconnect after first data phase
// RULE20: Reserved configuration bits read zero
// RULE21: Disabled space never claims
// Purpose: Target end decoding addresses and steering bytes to 8-bit registers
// Assumes: Master holds lines stable; inputs on the same clock as this end
// Notes:   Command block doubleword burst is not part of this block
`timescale 1ns/10ps
module ptd_target (
  input  wire logic       clk,
  input  wire logic       nrst,
  ptd_bus_if.target       bus,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWrStrobe,
  output logic            regRdStrobe,
  input  wire logic [7:0] regRdData,
  output logic            ioEnable,
  output logic            memEnable
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_DUAL  = 3'b001,
    S_CLAIM = 3'b011,
    S_WAIT  = 3'b010,
    S_DONE  = 3'b110,
    S_ABORT = 3'b111,
    S_TURN  = 3'b101
  } ptd_state_type;

  ptd_state_type state;
  ptd_state_type next_state;
  logic [3:0]  cmd;
  logic [31:0] addr;
  logic        isCfg;
  logic        isWrite;
  logic [2:0]  waitCnt;
  logic [23:0] ioBase;
  logic [29:0] memBase;
  logic [31:0] rdData;
  logic        lastPhase;

  // Address phase decode, all lines compared
  wire logic       addrPhase  = (state == S_IDLE) && !bus.frameN;
  wire logic       dualPhase  = (state == S_DUAL);
  wire logic [3:0] cmdNow     = dualPhase ? cmd : bus.cbeN ^ 4'hf; // RULE17
  wire logic [3:0] cmdEff     = (cmdNow == ptd_pkg::CMD_MEM_RDMUL
                                 || cmdNow == ptd_pkg::CMD_MEM_RDLN)
                                ? ptd_pkg::CMD_MEM_READ
                                : (cmdNow == ptd_pkg::CMD_MEM_WRINV
                                   ? ptd_pkg::CMD_MEM_WRITE : cmdNow);
  wire logic       isIoCmd    = cmdEff == ptd_pkg::CMD_IO_READ
                                || cmdEff == ptd_pkg::CMD_IO_WRITE;
  wire logic       isMemCmd   = cmdEff == ptd_pkg::CMD_MEM_READ
                                || cmdEff == ptd_pkg::CMD_MEM_WRITE;
  wire logic       isCfgCmd   = cmdEff == ptd_pkg::CMD_CFG_READ
                                || cmdEff == ptd_pkg::CMD_CFG_WRITE;
  wire logic       cfgHit     = isCfgCmd && bus.idsel
                                && bus.ad[1:0] == ptd_pkg::CFG_TYPE0; // RULE5 RULE7
  wire logic       ioHit      = isIoCmd && ioEnable
                                && bus.ad[31:ptd_pkg::IO_BASE_LSB] == ioBase; // RULE4 RULE9 RULE21
  wire logic       memHit     = isMemCmd && memEnable
                                && bus.ad[1:0] == ptd_pkg::BURST_LINEAR
                                && bus.ad[31:ptd_pkg::MEM_BASE_LSB] == memBase; // RULE13 RULE14 RULE15 RULE21
  // Dual address: upperZero is decoded but unused; a dual address cycle is never claimed
  wire logic       upperZero  = bus.ad == 32'h00000000;
  wire logic       hitNow     = addrPhase ? (cfgHit || ioHit || memHit) : 1'b0;
  wire logic       dualStart  = addrPhase && cmdNow == ptd_pkg::CMD_DUAL_ADDR; // RULE1

  // Data phase byte checks
  wire logic [3:0] beOn       = bus.cbeN ^ 4'hf;
  wire logic       beMulti    = (beOn & (beOn - 4'h1)) != 4'h0;
  wire logic       beNone     = beOn == 4'h0;
  wire logic [1:0] beLane     = beOn[1] ? 2'h1 : (beOn[2] ? 2'h2 : (beOn[3] ? 2'h3 : 2'h0));
  wire logic [7:0] laneByte   = bus.ad[8*beLane +: 8]; // RULE2
  wire logic [5:0] cfgIdx     = addr[ptd_pkg::CFG_REG_MSB:ptd_pkg::CFG_REG_LSB]; // RULE6
  wire logic [2:0] cfgFn      = addr[ptd_pkg::CFG_FN_MSB:ptd_pkg::CFG_FN_LSB];
  wire logic       byteAbort  = !isCfg && beMulti; // RULE18
  // Latched command, since the enables now sit where the command was
  wire logic       latchedIo  = cmd == ptd_pkg::CMD_IO_READ || cmd == ptd_pkg::CMD_IO_WRITE;
  wire logic [7:0] regOffset  = latchedIo ? addr[7:0] : {addr[7:2], beLane};
  wire logic [2:0] readWait   = (regOffset >= ptd_pkg::RAM_WINDOW)
                                ? ptd_pkg::READ_RAM_WAIT : ptd_pkg::READ_HW_WAIT;

  // Configuration read value, reserved bits zero
  always_comb begin
    rdData = 32'h00000000; // RULE20
    if (cfgFn == 3'h0) begin
      case (cfgIdx)
        ptd_pkg::CFG_IDX_CMD:   rdData = {30'h00000000, memEnable, ioEnable};
        ptd_pkg::CFG_IDX_IOBAR: rdData = {ioBase, 8'h01};
        ptd_pkg::CFG_IDX_MBAR:  rdData = {memBase, 2'h0};
        default:                rdData = 32'h00000000;
      endcase
    end
  end

  // State sequencing
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE:  next_state = dualStart ? S_DUAL : (hitNow ? S_CLAIM : S_IDLE);
      S_DUAL:  next_state = S_IDLE;
      S_CLAIM: next_state = byteAbort && !bus.irdyN ? S_ABORT : S_WAIT;
      S_WAIT:  next_state = byteAbort ? S_ABORT
                            : (waitCnt == 3'h0 && !bus.irdyN ? S_DONE : S_WAIT);
      S_DONE:  next_state = bus.frameN ? S_TURN : S_DONE;
      S_ABORT: next_state = bus.frameN ? S_TURN : S_ABORT;
      S_TURN:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // State and latched address phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= S_IDLE;
      cmd     <= 4'h0;
      addr    <= 32'h00000000;
      isCfg   <= 1'b0;
      isWrite <= 1'b0;
    end else begin
      state <= next_state;
      if (addrPhase) begin
        cmd     <= cmdEff;
        addr    <= bus.ad;
        isCfg   <= isCfgCmd;
        isWrite <= cmdEff[0];
      end
    end
  end

  // Hold-off counter: writes, configuration and register reads end three clocks after claim, RAM-window reads one later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitCnt <= 3'h0;
    end else if (state == S_CLAIM) begin
      waitCnt <= isWrite || isCfg ? ptd_pkg::WRITE_WAIT - 3'h1 : readWait - 3'h1; // RULE11 RULE12
    end else if (state == S_WAIT && waitCnt != 3'h0) begin
      waitCnt <= waitCnt - 3'h1;
    end
  end

  // Configuration writes honour byte enables; one function only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ioEnable  <= 1'b0;
      memEnable <= 1'b0;
      ioBase    <= ptd_pkg::IO_BASE_RESET;
      memBase   <= ptd_pkg::MEM_BASE_RESET;
    end else if (state == S_WAIT && next_state == S_DONE && isCfg && isWrite
                 && cfgFn == 3'h0) begin
      case (cfgIdx)
        ptd_pkg::CFG_IDX_CMD: if (beOn[0]) begin
          ioEnable  <= bus.ad[ptd_pkg::CMD_IO_EN_BIT];
          memEnable <= bus.ad[ptd_pkg::CMD_MEM_EN_BIT];
        end
        ptd_pkg::CFG_IDX_IOBAR: begin
          if (beOn[1]) ioBase[7:0]   <= bus.ad[15:8];
          if (beOn[2]) ioBase[15:8]  <= bus.ad[23:16];
          if (beOn[3]) ioBase[23:16] <= bus.ad[31:24];
        end
        ptd_pkg::CFG_IDX_MBAR: begin
          if (beOn[0]) memBase[5:0]   <= bus.ad[7:2];
          if (beOn[1]) memBase[13:6]  <= bus.ad[15:8];
          if (beOn[2]) memBase[21:14] <= bus.ad[23:16];
          if (beOn[3]) memBase[29:22] <= bus.ad[31:24];
        end
        default: ; // RULE20
      endcase
    end
  end

  // Register strobes and byte steering
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regAddr     <= 8'h00;
      regWrData   <= 8'h00;
      regWrStrobe <= 1'b0;
      regRdStrobe <= 1'b0;
    end else begin
      regWrStrobe <= state == S_WAIT && next_state == S_DONE && !isCfg && isWrite
                     && !beNone; // RULE11
      regRdStrobe <= state == S_CLAIM && !isCfg && !isWrite && !beNone;
      if (state == S_CLAIM) begin
        regAddr   <= regOffset; // RULE9 RULE15
        regWrData <= laneByte;
      end
    end
  end

  // Target outputs; driven from after turnaround, read data loaded the clock before ready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.adTarget   <= 32'h00000000;
      bus.adTargetOe <= 1'b0;
      lastPhase      <= 1'b0;
    end else begin
      lastPhase      <= !bus.frameN;
      bus.adTargetOe <= !isWrite && (next_state == S_WAIT || next_state == S_DONE)
                        && state != S_IDLE; // RULE16 RULE3
      if (state == S_WAIT && waitCnt == 3'h1) begin
        bus.adTarget <= isCfg ? rdData
                        : (beNone ? 32'h00000000 : {4{regRdData}}); // RULE2
      end
    end
  end

  // Handshake lines; stop marks disconnect on bursts, abort drops select
  assign bus.targetOe = state != S_IDLE && state != S_DUAL;
  assign bus.devselN  = !(state == S_WAIT || state == S_DONE
                          || (state == S_CLAIM && ptd_pkg::DEVSEL_DELAY == 3'h0)); // RULE10
  assign bus.trdyN    = state != S_DONE;
  assign bus.stopN    = !(state == S_ABORT || (state == S_DONE && !bus.frameN)); // RULE18 RULE19
endmodule : ptd_target

// file: src/ptd_pkg.sv
// Purpose: Shared constants for the target address decode and its bus master end
// Assumes: 32-bit multiplexed address/data bus, one clock at 25 MHz
// Notes:   Commands are the bus encodings, active-high form of the enable lines
package ptd_pkg;
  localparam logic [3:0] CMD_IO_READ   = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ  = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
  localparam logic [3:0] CMD_MEM_RDMUL = 4'hc;
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
  localparam logic [3:0] CMD_MEM_RDLN  = 4'he;
  localparam logic [3:0] CMD_MEM_WRINV = 4'hf;
  // Low address bit codes
  localparam logic [1:0] CFG_TYPE0     = 2'h0;
  localparam logic [1:0] CFG_TYPE1     = 2'h1;
  localparam logic [1:0] BURST_LINEAR  = 2'h0;
  // Field positions
  localparam int IO_BASE_LSB  = 8;
  localparam int MEM_BASE_LSB = 2;
  localparam int CFG_REG_LSB  = 2;
  localparam int CFG_REG_MSB  = 7;
  localparam int CFG_FN_LSB   = 8;
  localparam int CFG_FN_MSB   = 10;
  // Configuration register numbers (doubleword index)
  localparam logic [5:0] CFG_IDX_CMD   = 6'h01;
  localparam logic [5:0] CFG_IDX_IOBAR = 6'h04;
  localparam logic [5:0] CFG_IDX_MBAR  = 6'h05;
  // Command register enable bit positions
  localparam int CMD_IO_EN_BIT  = 0;
  localparam int CMD_MEM_EN_BIT = 1;
  // Reset values
  localparam logic [23:0] IO_BASE_RESET  = 24'h000000;
  localparam logic [29:0] MEM_BASE_RESET = 30'h00000000;
  // Wait-state counts in clocks
  localparam logic [2:0] WRITE_WAIT    = 3'h2; // Write done in three clocks
  localparam logic [2:0] READ_HW_WAIT  = 3'h2; // Turnaround plus one
  localparam logic [2:0] READ_RAM_WAIT = 3'h3; // One more for RAM data
  localparam logic [2:0] DEVSEL_DELAY  = 3'h1; // Medium decode speed
  localparam logic [3:0] MASTER_ABORT  = 4'h5; // Clocks without claim
  // Register window addresses at and above this take the RAM delay
  localparam logic [7:0] RAM_WINDOW    = 8'h80;
endpackage : ptd_pkg

// file: src/ptd_bus_if.sv
// Purpose: Bus wires between master end and target end
// Assumes: Active-low lines carry the n suffix, driven ones have an enable
// Notes:   Resolves shared lines from enables, no tristate in the ends
`timescale 1ns/10ps
interface ptd_bus_if;
  logic [31:0] adMaster;
  logic        adMasterOe;
  logic [31:0] adTarget;
  logic        adTargetOe;
  logic [31:0] ad;
  logic [3:0]  cbeN;
  logic        frameN;
  logic        irdyN;
  logic        idsel;
  logic        devselN;
  logic        trdyN;
  logic        stopN;
  logic        targetOe;
  logic        devselNBus;
  logic        trdyNBus;
  logic        stopNBus;

  // Handshake lines fall back to pulled-up idle and ad to zero when nobody drives
  assign ad         = adMasterOe ? adMaster : (adTargetOe ? adTarget : 32'h00000000);
  assign devselNBus = targetOe ? devselN : 1'b1;
  assign trdyNBus   = targetOe ? trdyN : 1'b1;
  assign stopNBus   = targetOe ? stopN : 1'b1;

  modport master (output adMaster, adMasterOe, cbeN, frameN, irdyN, idsel,
                  input ad, devselNBus, trdyNBus, stopNBus);
  modport target (output adTarget, adTargetOe, devselN, trdyN, stopN, targetOe,
                  input ad, cbeN, frameN, irdyN, idsel);
endinterface : ptd_bus_if

// file: src/ptd_master.sv
// Purpose: Bus master end issuing single transfers to the target end
// Assumes: User request holds until done pulses
// Notes:   Single data phase only; abort when nobody claims
`timescale 1ns/10ps
module ptd_master (
  input  wire logic        clk,
  input  wire logic        nrst,
  ptd_bus_if.master        bus,
  input  wire logic        reqValid,
  input  wire logic [3:0]  reqCmd,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqDual,
  input  wire logic [3:0]  reqByteEn,
  input  wire logic [31:0] reqData,
  input  wire logic        reqIdsel,
  output logic             done,
  output logic [31:0]      rspData,
  output logic             rspAbort
);
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_ADDR = 3'b001,
    M_HIGH = 3'b011,
    M_DATA = 3'b010,
    M_TURN = 3'b110
  } ptd_mstate_type;

  ptd_mstate_type mstate;
  logic [3:0]     timer;

  wire logic claimed = !bus.devselNBus;
  wire logic ended   = !bus.trdyNBus || !bus.stopNBus
                       || (!claimed && timer == ptd_pkg::MASTER_ABORT); // RULE8

  // Master sequence: address, optional upper address, one data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mstate         <= M_IDLE;
      timer          <= 4'h0;
      done           <= 1'b0;
      rspData        <= 32'h00000000;
      rspAbort       <= 1'b0;
      bus.adMaster   <= 32'h00000000;
      bus.adMasterOe <= 1'b0;
      bus.cbeN       <= 4'hf;
      bus.frameN     <= 1'b1;
      bus.irdyN      <= 1'b1;
      bus.idsel      <= 1'b0;
    end else begin
      done <= 1'b0;
      case (mstate)
        M_IDLE: if (reqValid && !done) begin
          mstate         <= M_ADDR;
          bus.frameN     <= 1'b0;
          bus.adMasterOe <= 1'b1;
          bus.adMaster   <= reqAddr; // RULE1
          bus.cbeN       <= (reqDual ? ptd_pkg::CMD_DUAL_ADDR : reqCmd) ^ 4'hf; // RULE17
          bus.idsel      <= reqIdsel;
        end
        M_ADDR: begin
          timer <= 4'h0;
          if (reqDual) begin
            mstate       <= M_HIGH;
            bus.adMaster <= 32'h00000000; // RULE1
            bus.cbeN     <= reqCmd ^ 4'hf;
          end else begin
            mstate         <= M_DATA;
            bus.frameN     <= 1'b1; // RULE19
            bus.irdyN      <= 1'b0;
            bus.cbeN       <= reqByteEn ^ 4'hf;
            bus.adMasterOe <= reqCmd[0];
            bus.adMaster   <= reqData; // RULE3
          end
        end
        M_HIGH: begin
          mstate         <= M_DATA;
          bus.frameN     <= 1'b1;
          bus.irdyN      <= 1'b0;
          bus.cbeN       <= reqByteEn ^ 4'hf;
          bus.adMasterOe <= reqCmd[0];
          bus.adMaster   <= reqData;
        end
        M_DATA: begin
          timer <= timer + 4'h1;
          if (ended) begin
            mstate         <= M_TURN;
            bus.irdyN      <= 1'b1;
            bus.adMasterOe <= 1'b0; // RULE16
            bus.cbeN       <= 4'hf;
            bus.idsel      <= 1'b0;
            rspAbort       <= !bus.trdyNBus ? 1'b0 : 1'b1;
            rspData        <= bus.ad;
            done           <= 1'b1;
          end
        end
        M_TURN: mstate <= M_IDLE; // Idle clock between transactions
        default: mstate <= M_IDLE;
      endcase
    end
  end
endmodule : ptd_master

// file: bench/ptd_checker.sv
// Purpose: Watches the bus between master end and target end
// Assumes: Command travels inverted on cbeN, as the master end drives it
// Notes:   Multi-enable accesses are left out of the wait-state timing checks
`timescale 1ns/10ps
module ptd_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [31:0] ad,
  input wire logic [31:0] adMaster,
  input wire logic        adMasterOe,
  input wire logic        adTargetOe,
  input wire logic [3:0]  cbeN,
  input wire logic        frameN,
  input wire logic        irdyN,
  input wire logic        idsel,
  input wire logic        devselNBus,
  input wire logic        trdyNBus,
  input wire logic        stopNBus
);
  logic        idleQ;
  logic [3:0]  cmdLat;
  logic [31:0] addrLat;
  logic        idselLat;
  logic        beMulti;
  logic        dacSeen;
  // Decode of the latched address phase
  wire addrPh = !frameN && idleQ;
  wire isCfg  = cmdLat[3:1] == 3'h5;
  wire isRd   = cmdLat == ptd_pkg::CMD_IO_READ || cmdLat == ptd_pkg::CMD_MEM_READ;
  wire slowRd = isRd && addrLat[7]; // Upper half of the window waits for RAM

  // Latches what the target saw, since the bus moves on before the claim
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idleQ    <= 1'b1;
      cmdLat   <= 4'h0;
      addrLat  <= 32'h0;
      idselLat <= 1'b0;
      beMulti  <= 1'b0;
      dacSeen  <= 1'b0;
    end else begin
      idleQ <= frameN && irdyN;
      if (addrPh) begin
        cmdLat   <= ~cbeN;
        addrLat  <= ad;
        idselLat <= idsel;
      end
      if (!irdyN) beMulti <= $countones(~cbeN) > 1;
      if (addrPh) dacSeen <= (~cbeN == ptd_pkg::CMD_DUAL_ADDR);
      else if (idleQ) dacSeen <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_DEVSEL_MEDIUM: assert property ($fell(devselNBus) |-> $past(addrPh, 2))
    else $error("claim not two clocks after address");
  AST_CFG_CLAIM: assert property ($fell(devselNBus) && isCfg |-> idselLat && addrLat[1:0] == ptd_pkg::CFG_TYPE0)
    else $error("configuration claim without select or type 0");
  AST_MEM_LINEAR: assert property ($fell(devselNBus) && cmdLat[3:1] == 3'h3 |-> addrLat[1:0] == ptd_pkg::BURST_LINEAR)
    else $error("memory claim with non-linear order");
  AST_NO_DAC: assert property (dacSeen |-> devselNBus)
    else $error("dual address cycle claimed");
  AST_FAST_TRDY: assert property ($fell(devselNBus) && !beMulti && !slowRd |-> trdyNBus [*2] ##1 !trdyNBus)
    else $error("ready not after three clocks");
  AST_SLOW_TRDY: assert property ($fell(devselNBus) && !beMulti && slowRd |-> trdyNBus [*3] ##1 !trdyNBus)
    else $error("RAM read ready not after four clocks");
  AST_WIDTH_ABORT: assert property (!stopNBus && devselNBus |-> beMulti)
    else $error("target abort without width error");
  AST_TURNAROUND: assert property ($rose(adTargetOe) |-> !adMasterOe && !$past(adMasterOe))
    else $error("target drives without a turnaround clock");
  AST_IDLE_GAP: assert property ($rose(irdyN) |-> frameN ##1 frameN)
    else $error("no idle clock after transaction");
  AST_STABLE: assert property (!irdyN && trdyNBus && $past(!irdyN && trdyNBus) && adMasterOe |-> $stable(adMaster) && $stable(cbeN))
    else $error("write data moved during wait");
  AST_LANES: assert property (!trdyNBus && adTargetOe && !isCfg |-> {3{ad[7:0]}} == ad[31:8])
    else $error("read byte not on every lane");
endmodule : ptd_checker

// file: bench/ptd_bench.sv
// Purpose: Self-checking run of master and target ends joined by the bus
// Assumes: Bench owns the 8-bit register file behind the target strobes
// Notes:   Expected bytes come from a bench model array, never the design
`timescale 1ns/10ps
module pci_target_address_decode_bench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reqValid = 1'b0;
  logic [3:0]  reqCmd = 4'h0;
  logic [31:0] reqAddr = 32'h0;
  logic        reqDual = 1'b0;
  logic [3:0]  reqByteEn = 4'h0;
  logic [31:0] reqData = 32'h0;
  logic        reqIdsel = 1'b0;
  logic        done, rspAbort, regWrStrobe, regRdStrobe, ioEnable, memEnable;
  logic [31:0] rspData;
  logic [7:0]  regAddr, regWrData, wrA, wrD;
  logic [7:0]  regFile [256];
  logic [7:0]  model [256];
  logic [31:0] seed = 32'h24;
  int          fail_count = 0;
  int          checks_done = 0;
  int          wrN = 0;
  int          rdN = 0;
  ptd_bus_if bus ();
  ptd_master i_ptd_master (.clk(clk), .nrst(nrst), .bus(bus), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqAddr(reqAddr), .reqDual(reqDual), .reqByteEn(reqByteEn),
    .reqData(reqData), .reqIdsel(reqIdsel), .done(done), .rspData(rspData), .rspAbort(rspAbort));
  ptd_target i_ptd_target (.clk(clk), .nrst(nrst), .bus(bus), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regFile[regAddr]), .ioEnable(ioEnable), .memEnable(memEnable));
  ptd_checker i_ptd_checker (.clk(clk), .nrst(nrst), .ad(bus.ad), .adMaster(bus.adMaster),
    .adMasterOe(bus.adMasterOe), .adTargetOe(bus.adTargetOe), .cbeN(bus.cbeN),
    .frameN(bus.frameN), .irdyN(bus.irdyN), .idsel(bus.idsel), .devselNBus(bus.devselNBus),
    .trdyNBus(bus.trdyNBus), .stopNBus(bus.stopNBus));

  always #20 clk = ~clk;

  // Register file behind the 8-bit strobes, counts every write
  always @(posedge clk) begin
    if (regWrStrobe === 1'b1) begin
      regFile[regAddr] <= regWrData;
      wrA <= regAddr;
      wrD <= regWrData;
      wrN <= wrN + 1;
    end
    if (regRdStrobe === 1'b1) rdN <= rdN + 1;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] cfgA(input logic [2:0] fn, input logic [5:0] idx);
    return {21'h0, fn, idx, 2'h0};
  endfunction : cfgA

  // Request held until done, then one clock of gap; a hang ends the run
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] d, input logic sel, input logic dl);
    bit ok;
    ok = 1'b0;
    reqCmd = c;
    reqAddr = a;
    reqByteEn = be;
    reqData = d;
    reqIdsel = sel;
    reqDual = dl;
    reqValid = 1'b1;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(posedge clk);
      #2;
      ok = (done === 1'b1);
    end
    reqValid = 1'b0;
    if (!ok) begin
      fail_count++;
      end_sim();
    end
    @(posedge clk);
    #2;
  endtask : xfer

  task automatic refuse(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                        input logic sel, input logic dl);
    xfer(c, a, be, 32'h5a5a5a5a, sel, dl);
    check(32'(rspAbort), 32'h1);
  endtask : refuse

  initial begin
    logic [31:0] iob;
    logic [31:0] mb;
    logic [31:0] a;
    logic [7:0]  d;
    logic [7:0]  r;
    logic [1:0]  l;
    int          n;
    iob = 32'h00c3d400;
    mb = 32'h8a5f00a4;
    repeat (2) @(posedge clk);
    #2;
    nrst = 1'b1;
    // Enable both spaces, store the bases, read one back
    xfer(ptd_pkg::CMD_CFG_WRITE, cfgA(3'h0, ptd_pkg::CFG_IDX_CMD), 4'hf, 32'h3, 1'b1, 1'b0);
    check(32'({ioEnable, memEnable}), 32'h3);
    xfer(ptd_pkg::CMD_CFG_WRITE, cfgA(3'h0, ptd_pkg::CFG_IDX_IOBAR), 4'hf, iob, 1'b1, 1'b0);
    xfer(ptd_pkg::CMD_CFG_WRITE, cfgA(3'h0, ptd_pkg::CFG_IDX_MBAR), 4'hf, mb, 1'b1, 1'b0);
    xfer(ptd_pkg::CMD_CFG_READ, cfgA(3'h0, ptd_pkg::CFG_IDX_IOBAR), 4'hf, 32'h0, 1'b1, 1'b0);
    check(rspData, {iob[31:8], 8'h01});
    xfer(ptd_pkg::CMD_CFG_READ, cfgA(3'h1, ptd_pkg::CFG_IDX_IOBAR), 4'hf, 32'h0, 1'b1, 1'b0);
    check(rspData, 32'h0);
    // Unselected type 0, then types 1 to 3 with select
    for (int t = 0; t < 4; t++) begin
      refuse(ptd_pkg::CMD_CFG_READ, cfgA(3'h0, 6'h01) | 32'(t), 4'hf, t != 0, 1'b0);
    end
    // Random byte registers through both spaces, written then read back
    for (int k = 0; k < 12; k++) begin
      d = 8'(rnd());
      l = 2'(rnd());
      r = k[0] ? {mb[7:2], l} : 8'(rnd());
      l = k[0] ? l : r[1:0];
      a = k[0] ? {mb[31:2], 2'h0} : {iob[31:8], r};
      n = wrN;
      xfer(k[0] ? ptd_pkg::CMD_MEM_WRITE : ptd_pkg::CMD_IO_WRITE, a, 4'h1 << l,
           32'(d) << (8 * l), 1'b0, 1'b0);
      model[r] = d;
      check(32'(wrN - n), 32'h1);
      check(32'(wrA), 32'(r));
      check(32'(wrD), 32'(d));
      n = rdN;
      xfer(k[0] ? ptd_pkg::CMD_MEM_READ : ptd_pkg::CMD_IO_READ, a, 4'h1 << l, 32'h0, 1'b0, 1'b0);
      check(32'(rdN - n), 32'h1);
      check(rspData, {4{model[r]}});
      check(32'(rspAbort), 32'h0);
    end
    // Width error, stray address lines, toggle order, dual address
    n = wrN;
    refuse(ptd_pkg::CMD_IO_WRITE, {iob[31:8], 8'h10}, 4'h3, 1'b0, 1'b0);
    for (int b = 8; b < 32; b += 11) begin
      refuse(ptd_pkg::CMD_IO_WRITE, {iob[31:8], 8'h10} ^ (32'h1 << b), 4'h1, 1'b0, 1'b0);
    end
    refuse(ptd_pkg::CMD_MEM_WRITE, {mb[31:2], 2'h1}, 4'h1, 1'b0, 1'b0);
    refuse(ptd_pkg::CMD_IO_WRITE, {iob[31:8], 8'h10}, 4'h1, 1'b0, 1'b1);
    check(32'(wrN - n), 32'h0);
    // Disabled spaces stay silent at a matching address
    xfer(ptd_pkg::CMD_CFG_WRITE, cfgA(3'h0, ptd_pkg::CFG_IDX_CMD), 4'hf, 32'h0, 1'b1, 1'b0);
    check(32'({ioEnable, memEnable}), 32'h0);
    refuse(ptd_pkg::CMD_IO_READ, {iob[31:8], 8'h10}, 4'h1, 1'b0, 1'b0);
    refuse(ptd_pkg::CMD_MEM_READ, {mb[31:2], 2'h0}, 4'h1, 1'b0, 1'b0);
    end_sim();
  end
endmodule : pci_target_address_decode_bench
